// >>> logic/acst_pkg.sv
// register map, field positions and reset values of the converter sequencer
package acst_pkg;
   localparam int          ADDR_W        = 10;
   localparam int          IDX_W         = 8;
   localparam int          RES_W         = 10;
   localparam int          CH_W          = 4;
   localparam int          PL_W          = 3;
   localparam int          VEC_W         = 6;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_THR_LO_A  = 8'hF0;
   localparam logic [7:0]  IDX_THR_LO_B  = 8'hF1;
   localparam logic [7:0]  IDX_THR_UP_A  = 8'hF2;
   localparam logic [7:0]  IDX_THR_UP_B  = 8'hF3;
   localparam logic [7:0]  IDX_CMP_FLAGS = 8'hF4;
   localparam logic [7:0]  IDX_CONV_DATA = 8'hF5;
   localparam logic [7:0]  IDX_SCAN_CTRL = 8'hFC;
   localparam logic [7:0]  IDX_RUN_CTRL  = 8'hFD;
   localparam logic [7:0]  IDX_IRQ_CTRL  = 8'hFE;
   localparam logic [7:0]  IDX_IRQ_VEC   = 8'hFF;
   // run control fields
   localparam int          RC_EXT_EN     = 4;
   localparam int          RC_INT_EN     = 3;
   localparam int          RC_POW        = 2;
   localparam int          RC_CONTINUOUS_MODE_SELECT       = 1;
   localparam int          RC_RUN        = 0;
   // scan control fields
   localparam int          SC_FIRST_LSB  = 4;
   localparam int          SC_CMP_LSB    = 0;
   // irq control fields
   localparam int          IC_EOC        = 7;
   localparam int          IC_AWD        = 6;
   localparam int          IC_EOC_IE     = 5;
   localparam int          IC_AWD_IE     = 4;
   localparam int          IC_PL_LSB     = 0;
   // irq vector fields
   localparam int          IV_VEC_LSB    = 2;
   localparam int          IV_WSEL       = 1;
   // conversion data fields
   localparam int          CD_CH_LSB     = 12;
   localparam int          CD_RES_LSB    = 0;
   // compare flag fields
   localparam int          CF_A          = 0;
   localparam int          CF_B          = 1;
   // reset values, last scan channel and channel step
   localparam logic [3:0]  RST_FIRST_CH  = 4'h0;
   localparam logic [3:0]  RST_CMP_CH    = 4'hF;
   localparam logic [2:0]  RST_PL        = 3'h7;
   localparam logic [9:0]  RST_THR_LO    = 10'h000;
   localparam logic [9:0]  RST_THR_UP    = 10'h3FF;
   localparam logic [5:0]  RST_VEC       = 6'h00;
   localparam logic        RST_WSEL      = 1'b1;
   localparam logic [3:0]  CH_LAST       = 4'hF;
   localparam logic [3:0]  CH_STEP       = 4'h1;

   typedef enum logic [2:0] {
      ACST_IDLE   = 3'b001,
      ACST_LAUNCH = 3'b010,
      ACST_WAIT   = 3'b100
   } acst_state_e;
endpackage

// >>> logic/acst_ctrl.sv
// converter sequencer: triggers, scan, window compare, flags, apb registers
`timescale 1ns/1ps
module acst_ctrl (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [9:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        trigger_input_pin_i,
   input  wire logic        timer_event_i,
   output logic             conv_power_o,
   output logic             conv_start_o,
   output logic      [3:0]  conv_channel_o,
   input  wire logic        conv_done_i,
   input  wire logic [9:0]  conv_result_i,
   output logic             irq_request_o,
   output logic      [2:0]  irq_priority_level_o,
   output logic      [7:0]  irq_vector_o
);

   typedef struct packed {
      acst_pkg::acst_state_e state;
      logic [3:0]            chan;
      logic                  external_trigger_enable;
      logic                  internal_trigger_enable;
      logic                  converter_power_on;
      logic                  continuous_mode_select;
      logic                  conversion_run;
      logic [3:0]            first_converted_channel;
      logic [3:0]            cmp_channel;
      logic [9:0]            thr_lo_a;
      logic [9:0]            thr_lo_b;
      logic [9:0]            thr_up_a;
      logic [9:0]            thr_up_b;
      logic                  end_of_conversion_flag;
      logic                  window_alarm_flag;
      logic                  eoc_irq_enable;
      logic                  window_alarm_irq_enable;
      logic [2:0]            irq_priority_level;
      logic [5:0]            vector_base;
      logic                  source_word_select;
      logic [1:0]            compare_result_flags;
      logic [9:0]            last_result;
      logic [3:0]            last_channel;
      logic [31:0]           prdata;
      logic                  pslverr;
      logic                  trig_s1;
      logic                  trig_s2;
      logic                  trig_d;
   } acst_regs_s;

   localparam acst_regs_s REGS_RESET = '{
      state:                   acst_pkg::ACST_IDLE,
      chan:                    acst_pkg::RST_FIRST_CH,
      first_converted_channel: acst_pkg::RST_FIRST_CH,
      cmp_channel:             acst_pkg::RST_CMP_CH,
      thr_lo_a:                acst_pkg::RST_THR_LO,
      thr_lo_b:                acst_pkg::RST_THR_LO,
      thr_up_a:                acst_pkg::RST_THR_UP,
      thr_up_b:                acst_pkg::RST_THR_UP,
      irq_priority_level:      acst_pkg::RST_PL,
      vector_base:             acst_pkg::RST_VEC,
      source_word_select:      acst_pkg::RST_WSEL,
      trig_s1:                 1'b1,
      trig_s2:                 1'b1,
      trig_d:                  1'b1,
      default:                 '0
   };

   acst_regs_s q;
   acst_regs_s next_q;

   logic [7:0] idx;
   logic       acc;
   logic       setup;
   logic       wr;
   logic       run_wr;
   logic       scan_wr;
   logic       icr_wr;
   logic       trig_fall;
   logic       ext_hit;
   logic       int_hit;
   logic       trig_hit;
   logic       conv_ack;
   logic       seq_end;
   logic [3:0] ch_a;
   logic       a_hit;
   logic       b_hit;
   assign idx      = paddr_i[9:2];
   assign setup    = psel_i & ~penable_i;
   assign acc      = psel_i & penable_i;
   assign wr       = acc & pwrite_i & ~q.pslverr;
   assign run_wr   = wr & (idx == acst_pkg::IDX_RUN_CTRL);
   assign scan_wr  = wr & (idx == acst_pkg::IDX_SCAN_CTRL);
   assign icr_wr   = wr & (idx == acst_pkg::IDX_IRQ_CTRL);
   // falling edge only after both sync stages
   assign trig_fall = q.trig_d & ~q.trig_s2;
   assign ext_hit   = trig_fall & q.external_trigger_enable;
   assign int_hit   = timer_event_i & q.internal_trigger_enable;
   assign trig_hit  = ext_hit | int_hit;
   assign conv_ack  = (q.state == acst_pkg::ACST_WAIT) & conv_done_i;
   assign seq_end   = conv_ack & (q.chan == acst_pkg::CH_LAST);
   // channel A sits one below B, so B=0 wraps A to 15
   assign ch_a      = 4'(q.cmp_channel - acst_pkg::CH_STEP);
   assign a_hit     = conv_ack & (q.chan == ch_a)
                    & ((conv_result_i > q.thr_up_a) | (conv_result_i < q.thr_lo_a));
   assign b_hit     = conv_ack & (q.chan == q.cmp_channel)
                    & ((conv_result_i > q.thr_up_b) | (conv_result_i < q.thr_lo_b));
   always_comb begin
      logic [31:0] rd;
      logic        mapped;
      rd     = '0;
      mapped = 1'b1;
      next_q = q;

      next_q.trig_s1 = trigger_input_pin_i;
      next_q.trig_s2 = q.trig_s1;
      next_q.trig_d  = q.trig_s2;
      // sequencer
      case (q.state)
         acst_pkg::ACST_IDLE: begin
            if (q.conversion_run & q.converter_power_on) begin
               next_q.state = acst_pkg::ACST_LAUNCH;
               next_q.chan  = q.first_converted_channel;
            end
         end
         acst_pkg::ACST_LAUNCH: begin
            next_q.state = acst_pkg::ACST_WAIT;
         end
         acst_pkg::ACST_WAIT: begin
            if (conv_ack) begin
               next_q.last_result  = conv_result_i;
               next_q.last_channel = q.chan;
               if (seq_end) begin
                  if (q.continuous_mode_select) begin
                     next_q.state = acst_pkg::ACST_LAUNCH;
                     next_q.chan  = q.first_converted_channel;
                  end else begin
                     next_q.state          = acst_pkg::ACST_IDLE;
                     next_q.conversion_run = 1'b0;
                  end
               end else begin
                  next_q.state = acst_pkg::ACST_LAUNCH;
                  next_q.chan  = 4'(q.chan + acst_pkg::CH_STEP);
               end
            end
         end
         default: begin
            next_q.state = acst_pkg::ACST_IDLE;
         end
      endcase
      // register writes
      if (wr) begin
         case (idx)
            acst_pkg::IDX_THR_LO_A: next_q.thr_lo_a = pwdata_i[9:0];
            acst_pkg::IDX_THR_LO_B: next_q.thr_lo_b = pwdata_i[9:0];
            acst_pkg::IDX_THR_UP_A: next_q.thr_up_a = pwdata_i[9:0];
            acst_pkg::IDX_THR_UP_B: next_q.thr_up_b = pwdata_i[9:0];
            acst_pkg::IDX_SCAN_CTRL: begin
               next_q.first_converted_channel = pwdata_i[acst_pkg::SC_FIRST_LSB +: 4];
               next_q.cmp_channel             = pwdata_i[acst_pkg::SC_CMP_LSB +: 4];
            end
            acst_pkg::IDX_RUN_CTRL: begin
               next_q.external_trigger_enable = pwdata_i[acst_pkg::RC_EXT_EN];
               next_q.internal_trigger_enable = pwdata_i[acst_pkg::RC_INT_EN];
               next_q.converter_power_on      = pwdata_i[acst_pkg::RC_POW];
               next_q.continuous_mode_select  = pwdata_i[acst_pkg::RC_CONTINUOUS_MODE_SELECT];
               next_q.conversion_run          = pwdata_i[acst_pkg::RC_RUN];
            end
            acst_pkg::IDX_IRQ_CTRL: begin
               next_q.eoc_irq_enable          = pwdata_i[acst_pkg::IC_EOC_IE];
               next_q.window_alarm_irq_enable = pwdata_i[acst_pkg::IC_AWD_IE];
               next_q.irq_priority_level      = pwdata_i[acst_pkg::IC_PL_LSB +: 3];
            end
            acst_pkg::IDX_IRQ_VEC: begin
               next_q.vector_base = pwdata_i[acst_pkg::IV_VEC_LSB +: 6];
            end
            default: begin
            end
         endcase
      end
      // an incoming trigger beats a same-cycle run clear
      if (trig_hit) begin
         next_q.conversion_run = 1'b1;
      end
      // a run or scan control write restarts the scan
      if (run_wr | scan_wr) begin
         if (next_q.conversion_run & next_q.converter_power_on) begin
            next_q.state = acst_pkg::ACST_LAUNCH;
            next_q.chan  = next_q.first_converted_channel;
         end else begin
            next_q.state = acst_pkg::ACST_IDLE;
         end
      end
      if (!next_q.converter_power_on) begin
         next_q.state = acst_pkg::ACST_IDLE;
      end
      // flags: software write loads, compare flags clear on write one, hardware set wins
      next_q.end_of_conversion_flag = (icr_wr ? pwdata_i[acst_pkg::IC_EOC]
                                      : q.end_of_conversion_flag) | seq_end;
      next_q.window_alarm_flag = (icr_wr ? pwdata_i[acst_pkg::IC_AWD]
                                 : q.window_alarm_flag) | a_hit | b_hit;
      next_q.compare_result_flags = (q.compare_result_flags
         & ~((wr & (idx == acst_pkg::IDX_CMP_FLAGS)) ? pwdata_i[1:0] : 2'h0))
         | {b_hit, a_hit};
      // alarm outranks end of conversion; end stays pending
      if (q.window_alarm_flag & q.window_alarm_irq_enable) begin
         next_q.source_word_select = 1'b0;
      end else if (q.end_of_conversion_flag & q.eoc_irq_enable) begin
         next_q.source_word_select = 1'b1;
      end
      // read data captured in setup so prdata comes from a flop
      case (idx)
         acst_pkg::IDX_THR_LO_A:  rd[9:0] = q.thr_lo_a;
         acst_pkg::IDX_THR_LO_B:  rd[9:0] = q.thr_lo_b;
         acst_pkg::IDX_THR_UP_A:  rd[9:0] = q.thr_up_a;
         acst_pkg::IDX_THR_UP_B:  rd[9:0] = q.thr_up_b;
         acst_pkg::IDX_CMP_FLAGS: rd[1:0] = q.compare_result_flags;
         acst_pkg::IDX_CONV_DATA: begin
            rd[acst_pkg::CD_RES_LSB +: 10] = q.last_result;
            rd[acst_pkg::CD_CH_LSB +: 4]   = q.last_channel;
         end
         acst_pkg::IDX_SCAN_CTRL: begin
            rd[acst_pkg::SC_FIRST_LSB +: 4] = q.first_converted_channel;
            rd[acst_pkg::SC_CMP_LSB +: 4]   = q.cmp_channel;
         end
         acst_pkg::IDX_RUN_CTRL: begin
            rd[acst_pkg::RC_EXT_EN] = q.external_trigger_enable;
            rd[acst_pkg::RC_INT_EN] = q.internal_trigger_enable;
            rd[acst_pkg::RC_POW]    = q.converter_power_on;
            rd[acst_pkg::RC_CONTINUOUS_MODE_SELECT]   = q.continuous_mode_select;
            rd[acst_pkg::RC_RUN]    = q.conversion_run;
         end
         acst_pkg::IDX_IRQ_CTRL: begin
            rd[acst_pkg::IC_EOC]        = q.end_of_conversion_flag;
            rd[acst_pkg::IC_AWD]        = q.window_alarm_flag;
            rd[acst_pkg::IC_EOC_IE]     = q.eoc_irq_enable;
            rd[acst_pkg::IC_AWD_IE]     = q.window_alarm_irq_enable;
            rd[acst_pkg::IC_PL_LSB +: 3] = q.irq_priority_level;
         end
         acst_pkg::IDX_IRQ_VEC: begin
            rd[acst_pkg::IV_VEC_LSB +: 6] = q.vector_base;
            rd[acst_pkg::IV_WSEL]         = q.source_word_select;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
      if (setup) begin
         next_q.prdata  = rd;
         next_q.pslverr = ~mapped;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         q <= REGS_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign prdata_o             = q.prdata;
   assign pready_o             = acc;
   assign pslverr_o            = acc & q.pslverr;
   assign conv_power_o         = q.converter_power_on;
   // a done still in flight from a restarted scan is dropped in launch
   assign conv_start_o         = (q.state == acst_pkg::ACST_LAUNCH);
   assign conv_channel_o       = q.chan;
   assign irq_request_o        = (q.end_of_conversion_flag & q.eoc_irq_enable)
                               | (q.window_alarm_flag & q.window_alarm_irq_enable);
   assign irq_priority_level_o = q.irq_priority_level;
   assign irq_vector_o         = {q.vector_base, q.source_word_select, 1'b0};
   // checks
   logic quiet;
   assign quiet = ~wr;

   property p_ext_ignored;
      @(posedge core_clk_i) disable iff (rst_i)
      (trig_fall & ~q.external_trigger_enable & ~timer_event_i & ~q.conversion_run
       & q.state == acst_pkg::ACST_IDLE & quiet) |=> ~q.conversion_run;
   endproperty
   a_ext_ignored: assert property (p_ext_ignored)
      else $error("disabled pin trigger started a run");
   property p_timer_start;
      @(posedge core_clk_i) disable iff (rst_i)
      (timer_event_i & q.internal_trigger_enable & q.converter_power_on & quiet)
         |=> q.conversion_run ##1 (q.state != acst_pkg::ACST_IDLE);
   endproperty
   a_timer_start: assert property (p_timer_start)
      else $error("timer event did not start a sequence");
   property p_single_end;
      @(posedge core_clk_i) disable iff (rst_i)
      (seq_end & ~q.continuous_mode_select & ~trig_hit & quiet)
         |=> (~q.conversion_run & q.state == acst_pkg::ACST_IDLE & q.end_of_conversion_flag);
   endproperty
   a_single_end: assert property (p_single_end)
      else $error("single sequence did not stop with end flag");
   property p_continuous_mode_select_repeat;
      @(posedge core_clk_i) disable iff (rst_i)
      (seq_end & q.continuous_mode_select & quiet)
         |=> (conv_start_o & conv_channel_o == $past(q.first_converted_channel));
   endproperty
   a_continuous_mode_select_repeat: assert property (p_continuous_mode_select_repeat)
      else $error("continuous mode did not relaunch from first channel");
   property p_restart;
      @(posedge core_clk_i) disable iff (rst_i)
      (run_wr & pwdata_i[acst_pkg::RC_RUN] & pwdata_i[acst_pkg::RC_POW])
         |=> (conv_start_o & conv_channel_o == q.first_converted_channel) ##1 ~conv_start_o;
   endproperty
   a_restart: assert property (p_restart)
      else $error("control write did not restart the scan");
   property p_stop;
      @(posedge core_clk_i) disable iff (rst_i)
      (run_wr & ~pwdata_i[acst_pkg::RC_RUN] & ~trig_hit)
         |=> (~conv_start_o & ~q.conversion_run)[*2];
   endproperty
   a_stop: assert property (p_stop)
      else $error("run clear did not stop conversion");
   property p_power_down;
      @(posedge core_clk_i) disable iff (rst_i)
      ~q.converter_power_on |-> ~conv_start_o & ~conv_power_o;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("conversion launched while powered down");
   property p_step;
      @(posedge core_clk_i) disable iff (rst_i)
      (conv_ack & ~seq_end & quiet)
         |=> (conv_start_o & conv_channel_o == 4'($past(q.chan) + acst_pkg::CH_STEP));
   endproperty
   a_step: assert property (p_step)
      else $error("scan did not advance to the next channel");
   property p_alarm;
      @(posedge core_clk_i) disable iff (rst_i)
      (a_hit | b_hit) |=> (q.window_alarm_flag & (|q.compare_result_flags));
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("window excursion not flagged");
   property p_sw_irq;
      @(posedge core_clk_i) disable iff (rst_i)
      (icr_wr & pwdata_i[acst_pkg::IC_EOC] & pwdata_i[acst_pkg::IC_EOC_IE])
         |=> irq_request_o ##1 irq_vector_o[acst_pkg::IV_WSEL] | q.window_alarm_flag;
   endproperty
   a_sw_irq: assert property (p_sw_irq)
      else $error("software flag set raised no request");
   property p_mask;
      @(posedge core_clk_i) disable iff (rst_i)
      (~q.eoc_irq_enable & ~q.window_alarm_irq_enable) |-> ~irq_request_o;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked request forwarded");
   property p_alarm_first;
      @(posedge core_clk_i) disable iff (rst_i)
      (q.window_alarm_flag & q.window_alarm_irq_enable)
         |=> ~irq_vector_o[acst_pkg::IV_WSEL];
   endproperty
   a_alarm_first: assert property (p_alarm_first)
      else $error("alarm did not take the lower vector word");
   c_single_seq: cover property (@(posedge core_clk_i) disable iff (rst_i)
      seq_end & ~q.continuous_mode_select);
   c_continuous_mode_select_seq: cover property (@(posedge core_clk_i) disable iff (rst_i)
      seq_end & q.continuous_mode_select);
   c_pin_start: cover property (@(posedge core_clk_i) disable iff (rst_i) ext_hit);
   c_both_flags: cover property (@(posedge core_clk_i) disable iff (rst_i)
      q.window_alarm_flag & q.end_of_conversion_flag & irq_request_o);

endmodule // acst_ctrl

// >>> dv/acst_far_model.sv
// trigger pin, timer event and converter answer seen from the sequencer
`timescale 1ns/1ps
module acst_far_model (
   input  wire logic       core_clk_i,
   input  wire logic       pin_req_i,
   input  wire logic       tmr_req_i,
   input  wire logic       conv_start_i,
   input  wire logic [3:0] done_delay_i,
   output logic            trigger_input_pin_o,
   output logic            timer_event_o,
   output logic            conv_done_o
);
   logic [2:0] pin_cnt  = 3'h0;
   logic [4:0] wait_cnt = 5'h0;
   // outputs settle on the first edge, well inside reset
   always @(posedge core_clk_i) begin
      if (pin_req_i)
         pin_cnt <= 3'h4;
      else if (pin_cnt != 3'h0)
         pin_cnt <= pin_cnt - 3'h1;
      // low four clocks, so the two-flop sync always sees it
      trigger_input_pin_o <= !(pin_req_i || pin_cnt > 3'h1);
      timer_event_o <= tmr_req_i;
      conv_done_o <= wait_cnt == 5'h1;
      if (conv_start_i === 1'h1)
         wait_cnt <= {1'h0, done_delay_i} + 5'h1;
      else if (wait_cnt != 5'h0)
         wait_cnt <= wait_cnt - 5'h1;
   end
endmodule // acst_far_model

// >>> dv/adc_sequence_trigger_irq_ctrl_tb_top.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adc_sequence_trigger_irq_ctrl_tb_top;
   localparam logic [7:0] RC = acst_pkg::IDX_RUN_CTRL;
   localparam logic [7:0] IC = acst_pkg::IDX_IRQ_CTRL;
   localparam logic [7:0] IV = acst_pkg::IDX_IRQ_VEC;
   logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
   logic        pin_rq = 1'h0, tmr_rq = 1'h0, rdy, err, e, pin, tmr, start, done, irq, pwron;
   logic [9:0]  paddr = 10'h0, res = 10'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [3:0]  ch, dly = 4'h3;
   logic [2:0]  pl;
   logic [7:0]  vec, lf = 8'h50;
   logic [3:0]  chq[$];
   int          failures = 0, tests_run = 0, n0;
   acst_ctrl DUT (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
      .pslverr_o(err), .trigger_input_pin_i(pin), .timer_event_i(tmr), .conv_power_o(pwron),
      .conv_start_o(start), .conv_channel_o(ch), .conv_done_i(done), .conv_result_i(res),
      .irq_request_o(irq), .irq_priority_level_o(pl), .irq_vector_o(vec));
   acst_far_model far (.core_clk_i(clk), .pin_req_i(pin_rq), .tmr_req_i(tmr_rq),
      .conv_start_i(start), .done_delay_i(dly), .trigger_input_pin_o(pin),
      .timer_event_o(tmr), .conv_done_o(done));
   initial forever #4 clk = ~clk;
   always @(posedge clk) if (start === 1'h1) chq.push_back(ch);
   function automatic logic [7:0] nx(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic out_win(input logic [9:0] r, lo, up);
      return (r > up) || (r < lo);
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic bail();
      failures++;
      $display("Error at %0t: wait ran out", $time);
      final_report();
   endtask
   task automatic chk(input logic [31:0] g, x);
      tests_run++;
      if (g !== x) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwr <= w;
      paddr <= {i, 2'h0};
      pwdata <= d;
      @(posedge clk) pen <= 1'h1;
      do @(posedge clk); while (rdy !== 1'h1 && ++n < 50);
      if (n >= 50) bail();
      rd = prdata;
      e = err;
      psel <= 1'h0;
      pen <= 1'h0;
      // two idle edges let registered flags and vector settle
      repeat (2) @(posedge clk);
   endtask
   task automatic wt(input int k);
      int n;
      n = 0;
      while ((k == 0 ? irq !== 1'h1 : chq.size() < k) && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) bail();
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      apb(1'h0, IC, 32'h0);
      chk(rd, 32'h07);
      apb(1'h0, IV, 32'h0);
      chk(rd[1:0], 32'h2);
      chk(pwron, 32'h0);
      apb(1'h0, 8'h10, 32'h0);
      chk(e, 32'h1);
      apb(1'h1, acst_pkg::IDX_SCAN_CTRL, 32'hEF);
      apb(1'h1, IC, 32'h20);
      chq.delete();
      apb(1'h1, RC, 32'h05);
      wt(0);
      chk(chq.size(), 32'h2);
      chk(chq[0], 32'hE);
      chk(chq[1], 32'hF);
      chk(pwron, 32'h1);
      apb(1'h0, RC, 32'h0);
      chk(rd, 32'h04);
      apb(1'h0, IC, 32'h0);
      chk(rd, 32'hA0);
      chk(irq, 32'h1);
      apb(1'h1, IC, 32'h83);
      chk(irq, 32'h0);
      chk(pl, 32'h3);
      // clear first so the next set is software's alone
      apb(1'h1, IC, 32'h20);
      apb(1'h0, IC, 32'h0);
      chk(rd, 32'h20);
      apb(1'h1, IC, 32'hA0);
      chk(irq, 32'h1);
      apb(1'h1, IV, 32'hFC);
      chk(vec, 32'hFE);
      // enables clear then set, and under each setting pin then timer
      for (int k = 0; k < 4; k++) begin
         apb(1'h1, IC, 32'h20);
         apb(1'h1, RC, k[1] ? (k[0] ? 32'h0C : 32'h14) : 32'h04);
         lf = nx(lf);
         dly <= lf[3:0];
         res <= {2'h0, lf};
         n0 = chq.size();
         if (k[0])
            tmr_rq <= 1'h1;
         else
            pin_rq <= 1'h1;
         @(posedge clk);
         tmr_rq <= 1'h0;
         pin_rq <= 1'h0;
         if (k[1])
            wt(0);
         else
            repeat (40) @(posedge clk);
         chk(chq.size() - n0, k[1] ? 32'h2 : 32'h0);
      end
      apb(1'h1, IC, 32'h30);
      apb(1'h1, acst_pkg::IDX_THR_UP_B, 32'h100);
      res <= 10'h200;
      apb(1'h1, RC, 32'h05);
      wt(0);
      apb(1'h0, IC, 32'h0);
      chk(rd, {24'h0, 1'h1, out_win(10'h200, 10'h0, 10'h100), 6'h30});
      apb(1'h0, acst_pkg::IDX_CMP_FLAGS, 32'h0);
      chk(rd, {30'h0, out_win(10'h200, 10'h0, 10'h100), out_win(10'h200, 10'h0, 10'h3FF)});
      apb(1'h0, acst_pkg::IDX_CONV_DATA, 32'h0);
      chk(rd, 32'hF200);
      chk(vec[1:0], 32'h0);
      apb(1'h1, IC, 32'hB0);
      chk(vec[1:0], 32'h2);
      apb(1'h1, IC, 32'h20);
      res <= 10'h050;
      dly <= 4'hF;
      chq.delete();
      apb(1'h1, RC, 32'h05);
      wt(2);
      apb(1'h1, RC, 32'h05);
      wt(0);
      chk(chq.size(), 32'h4);
      chk(chq[2], 32'hE);
      chq.delete();
      dly <= 4'h1;
      apb(1'h1, RC, 32'h07);
      wt(6);
      apb(1'h1, RC, 32'h04);
      n0 = chq.size();
      repeat (30) @(posedge clk);
      chk(chq.size() - n0, 32'h0);
      apb(1'h1, RC, 32'h01);
      n0 = chq.size();
      repeat (30) @(posedge clk);
      chk(chq.size() - n0, 32'h0);
      chk(pwron, 32'h0);
      final_report();
   end
endmodule // adc_sequence_trigger_irq_ctrl_tb_top
